// *** core/ldc_dbc_if.sv ***
// signals between the port core and one fault pulse counter
// assumes both ends run on the core clock
`timescale 1ns/10ps
interface ldc_dbc_if;
  logic dim_high;
  logic dim_fall;
  logic cond;
  logic clr;
  logic hit;
  modport core (output dim_high, output dim_fall, output cond, output clr, input hit);
  modport cnt (input dim_high, input dim_fall, input cond, input clr, output hit);
endinterface

// *** core/ldc_diag_port.sv ***
// diagnostic and command port of a two-string led driver, with apb status/control
// assumes analog comparator flags and pins arrive asynchronously to I_CLK
// Operation
// - serial bits both ways move on channel-one pwm falling edges, even when disabled.
// - no serial transfer while channel-one pwm holds steady.
// - power-good and over-temperature are static levels, independent of pwm.
// - line low after startup, released once feedback sense reaches power-good.
// - over-temperature drives line low; released when flag clears; operation continues.
// - under-voltage fault after 508 pulses of low sink with headroom at maximum.
// - over-voltage fault after 508 pulses of high sink voltage.
// - patterns: ov1 0001, ov2 0011, uv1 0101, uv2 0111.
// - latched pattern keeps showing after the fault disappears.
// - pattern cleared by shutdown, enable low, or over-temperature; here over-temperature only hides it and the pattern is kept.
// - after a clear a new full 508-pulse run is needed.
// - over-temperature forces line low above any pattern.
// - each sink conducts only while its own pwm is high.
// - pwm inputs float low when unconnected.
// - 16-bit frequency commands: normal, down 20, down 40; normal at reset.
// - channel-one-off command; channel one enabled after reset.
// - commands ignored before power-good, during over-temperature or a pattern.
// - enable low restores normal frequency and re-enables channel one.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module ldc_diag_port
  import ldc_pkg::*;
#(
  parameter int PULSES = LDC_FAULT_PULSES
)(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CHANNEL_ONE_PWM,
  input wire logic I_CHANNEL_TWO_PWM,
  input wire logic I_ENABLE,
  input wire logic I_SHUTDOWN,
  input wire logic I_OVER_TEMP,
  input wire logic I_POWER_GOOD,
  input wire logic [1:0] I_SINK_LOW,
  input wire logic [1:0] I_SINK_HIGH,
  input wire logic I_HEADROOM_MAX,
  input wire logic I_DIAG_IO_LINE_I,
  output logic O_DIAG_IO_LINE_O,
  output logic O_DIAG_IO_LINE_OE,
  output logic [1:0] O_SINK_EN,
  output logic [1:0] O_FREQ_SEL,
  output logic O_CH1_EN
);
  if (PULSES < 2)
  begin : g_bad_pulses
    $error("PULSES must be at least 2");
  end
  // ****************************************
  // synchronisers
  // ****************************************
  // pwm inputs rely on the pad pull-down; an open pin shows a steady low
  logic [LDC_SYNC_W-1:0] s1_q;
  logic [LDC_SYNC_W-1:0] s2_q;
  logic channel_one_pwm_prev_q;
  logic channel_two_pwm_prev_q;
  wire [LDC_SYNC_W-1:0] raw = {I_DIAG_IO_LINE_I, I_HEADROOM_MAX, I_SINK_HIGH, I_SINK_LOW,
    I_POWER_GOOD, I_OVER_TEMP, I_SHUTDOWN, I_ENABLE, I_CHANNEL_TWO_PWM, I_CHANNEL_ONE_PWM};
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      s1_q <= '0;
      s2_q <= '0;
      channel_one_pwm_prev_q <= 1'b0;
      channel_two_pwm_prev_q <= 1'b0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      channel_one_pwm_prev_q <= s2_q[0];
      channel_two_pwm_prev_q <= s2_q[1];
    end
  end
  wire channel_one_pwm_s = s2_q[0];
  wire channel_two_pwm_s = s2_q[1];
  wire en_low = !s2_q[2];
  wire shdn_s = s2_q[3];
  wire hot_s = s2_q[4];
  wire pgood_s = s2_q[5];
  wire [1:0] low_s = s2_q[7:6];
  wire [1:0] high_s = s2_q[9:8];
  wire hdrm_s = s2_q[10];
  wire line_s = s2_q[11];
  // slow pull-up limits how soon after the edge a bit is valid outside
  wire channel_one_pwm_fall = channel_one_pwm_prev_q & !channel_one_pwm_s;
  wire channel_two_pwm_fall = channel_two_pwm_prev_q & !channel_two_pwm_s;
  // ****************************************
  // apb registers
  // ****************************************
  logic [1:0] ctrl_q;
  logic [15:0] cmd_last_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire apb_acc = I_PSEL & I_PENABLE & !pready_q;
  wire hit_ctrl = (I_PADDR == LDC_OFS_CTRL);
  wire hit_stat = (I_PADDR == LDC_OFS_STAT);
  wire hit_cmd = (I_PADDR == LDC_OFS_CMD);
  wire mapped = hit_ctrl | hit_stat | hit_cmd;
  wire ctrl_wr = apb_acc & I_PWRITE & hit_ctrl;
  wire soft_clr = ctrl_wr & I_PWDATA[LDC_CTRL_SOFT_CLR_BIT];
  wire cmd_en = ctrl_q[LDC_CTRL_CMD_EN_BIT];
  logic [3:0] pat_q;
  logic pat_valid_q;
  ldc_freq_t freq_q;
  logic ch1_en_q;
  wire [31:0] stat_word = {22'h0, 2'(freq_q), ch1_en_q, hot_s, pgood_s, pat_valid_q, pat_q};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
    hit_stat ? stat_word : hit_cmd ? {16'h0000, cmd_last_q} : 32'h00000000;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      ctrl_q <= LDC_CTRL_RST;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc & !mapped;
      prdata_q <= (apb_acc & !I_PWRITE) ? rd_mux : prdata_q;
      // soft clear is a self-clearing strobe, only the enable bit is stored
      if (ctrl_wr)
        ctrl_q <= {1'b0, I_PWDATA[LDC_CTRL_CMD_EN_BIT]};
    end
  end
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_PRDATA = prdata_q;
  // ****************************************
  // fault counters
  // ****************************************
  // over-temperature resets the runs; the pattern itself is only hidden
  wire dbc_clr = en_low | shdn_s | hot_s | soft_clr;
  wire [3:0] dbc_cond = {hdrm_s & low_s[1], hdrm_s & low_s[0], high_s[1], high_s[0]};
  wire [3:0] dbc_high = {channel_two_pwm_s, channel_one_pwm_s, channel_two_pwm_s, channel_one_pwm_s};
  wire [3:0] dbc_fall = {channel_two_pwm_fall, channel_one_pwm_fall, channel_two_pwm_fall, channel_one_pwm_fall};
  wire [3:0] hits;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cnt
      ldc_dbc_if u_if ();
      assign u_if.dim_high = dbc_high[gi];
      assign u_if.dim_fall = dbc_fall[gi];
      assign u_if.cond = dbc_cond[gi];
      assign u_if.clr = dbc_clr;
      assign hits[gi] = u_if.hit;
      ldc_fault_cnt #(.PULSES(PULSES)) u_cnt (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .dbc(u_if.cnt)
      );
    end
  endgenerate
  function automatic logic [3:0] pick_pat(input logic [3:0] h);
    // simultaneous hits: over-voltage of string one first
    if (h[0])
      return LDC_PAT_OV1;
    else if (h[1])
      return LDC_PAT_OV2;
    else if (h[2])
      return LDC_PAT_UV1;
    else
      return LDC_PAT_UV2;
  endfunction
  // ****************************************
  // pattern latch
  // ****************************************
  wire any_hit = |hits;
  wire pat_clr = en_low | shdn_s | soft_clr;
  logic [1:0] bit_idx_q;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pat_q <= '0;
      pat_valid_q <= 1'b0;
      bit_idx_q <= '0;
    end
    else if (any_hit)
    begin
      // a later fault overwrites the latched pattern and restarts the bit index
      pat_q <= pick_pat(hits);
      pat_valid_q <= 1'b1;
      bit_idx_q <= '0;
    end
    else if (pat_clr)
    begin
      pat_q <= '0;
      pat_valid_q <= 1'b0;
      bit_idx_q <= '0;
    end
    else if (pat_valid_q && !hot_s && channel_one_pwm_fall)
      bit_idx_q <= bit_idx_q + 1'b1;
  end
  // ****************************************
  // line state and commands
  // ****************************************
  ldc_state_t state_d;
  assign state_d = !pgood_s ? LDC_ST_START :
    hot_s ? LDC_ST_HOT :
    pat_valid_q ? LDC_ST_REPORT : LDC_ST_IDLE;
  wire [1:0] msb_idx = 2'd3 - bit_idx_q;
  wire cur_bit = pat_q[msb_idx];
  logic oe_d;
  always_comb
  begin
    case (state_d)
      LDC_ST_START: oe_d = 1'b1;
      LDC_ST_HOT: oe_d = 1'b1;
      LDC_ST_REPORT: oe_d = !cur_bit;
      LDC_ST_IDLE: oe_d = 1'b0;
      default: oe_d = 1'b1;
    endcase
  end
  wire accept = (state_d == LDC_ST_IDLE) & cmd_en;
  logic [15:0] cmd_sr_q;
  wire [15:0] cmd_next = {cmd_sr_q[14:0], line_s};
  wire take = accept & channel_one_pwm_fall;
  wire is_norm = take & (cmd_next == LDC_CMD_NORM);
  wire is_dn20 = take & (cmd_next == LDC_CMD_DN20);
  wire is_dn40 = take & (cmd_next == LDC_CMD_DN40);
  wire is_off = take & (cmd_next == LDC_CMD_CH1_OFF);
  wire is_cmd = is_norm | is_dn20 | is_dn40 | is_off;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      cmd_sr_q <= '0;
      cmd_last_q <= '0;
      freq_q <= LDC_FREQ_NORM;
      ch1_en_q <= 1'b1;
    end
    else
    begin
      // partial commands are dropped when acceptance lapses
      cmd_sr_q <= !accept ? '0 : (is_cmd ? '0 : (take ? cmd_next : cmd_sr_q));
      cmd_last_q <= is_cmd ? cmd_next : cmd_last_q;
      if (en_low)
      begin
        freq_q <= LDC_FREQ_NORM;
        ch1_en_q <= 1'b1;
      end
      else
      begin
        if (is_norm)
          freq_q <= LDC_FREQ_NORM;
        else if (is_dn20)
          freq_q <= LDC_FREQ_DN20;
        else if (is_dn40)
          freq_q <= LDC_FREQ_DN40;
        if (is_off)
          ch1_en_q <= 1'b0;
      end
    end
  end
  // ****************************************
  // pin outputs
  // ****************************************
  logic oe_q;
  logic [1:0] sink_q;
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      oe_q <= 1'b1;
      sink_q <= '0;
    end
    else
    begin
      oe_q <= oe_d;
      // tied sinks stay aligned only if the controller ties the pwm inputs too
      sink_q <= {channel_two_pwm_s, channel_one_pwm_s & ch1_en_q};
    end
  end
  assign O_DIAG_IO_LINE_O = 1'b0;
  assign O_DIAG_IO_LINE_OE = oe_q;
  assign O_SINK_EN = sink_q;
  assign O_FREQ_SEL = 2'(freq_q);
  assign O_CH1_EN = ch1_en_q;
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  AST_START_LOW: assert property (!pgood_s |=> O_DIAG_IO_LINE_OE)
    else $error("line not low before power good");
  AST_HOT_LOW: assert property (hot_s && pat_valid_q |=> O_DIAG_IO_LINE_OE)
    else $error("over-temperature did not override pattern");
  AST_IDLE_RELEASE: assert property (pgood_s && !hot_s && !pat_valid_q && !any_hit
    |=> !O_DIAG_IO_LINE_OE)
    else $error("line not released in idle");
  AST_STEADY_PWM: assert property (!channel_one_pwm_fall && !any_hit && !pat_clr
    |=> $stable(bit_idx_q) && $stable(cmd_last_q))
    else $error("serial activity without falling edge");
  AST_CLEAR: assert property (pat_clr && !any_hit |=> !pat_valid_q)
    else $error("pattern not cleared");
  AST_HOLD: assert property (pat_valid_q && !pat_clr && !any_hit
    |=> pat_valid_q && $stable(pat_q))
    else $error("pattern lost while latched");
  AST_EN_RESTORE: assert property (en_low |=> freq_q == LDC_FREQ_NORM && ch1_en_q)
    else $error("enable low did not restore defaults");
  AST_CH1_OFF: assert property (is_off && !en_low |=> !ch1_en_q ##1 !O_SINK_EN[0])
    else $error("channel one not switched off");
  AST_NO_CMD: assert property (!accept && !en_low |=> $stable(freq_q) && $stable(ch1_en_q))
    else $error("command taken while refused");
  AST_SINK2: assert property (O_SINK_EN[1] == $past(channel_two_pwm_s))
    else $error("string two sink not following its pwm");
  AST_PAT_OV1: assert property (hits[0] |=> pat_valid_q && pat_q == LDC_PAT_OV1)
    else $error("string one over-voltage pattern wrong");
  // every pattern starts with a zero, so the line drops as soon as one latches
  AST_REPORT_MSB: assert property (any_hit |=> ##1 O_DIAG_IO_LINE_OE)
    else $error("pattern msb not shown first");
  AST_DN40_SET: assert property (is_dn40 && !en_low |=> O_FREQ_SEL == 2'(LDC_FREQ_DN40))
    else $error("down 40 command not applied");
  COV_PATTERN: cover property (any_hit ##1 pat_valid_q);
  COV_HOT_RESUME: cover property (pat_valid_q && hot_s ##[1:50] pat_valid_q && !hot_s);
  COV_CMD: cover property (is_dn40);
  COV_SOFT_CLR: cover property (soft_clr && pat_valid_q);
  COV_CH1_OFF: cover property (is_off);
endmodule // ldc_diag_port

// *** core/ldc_fault_cnt.sv ***
// counts consecutive dimming pulses that carried a fault condition
// assumes synchronised dimming level, falling-edge strobe and condition
`timescale 1ns/10ps
module ldc_fault_cnt
  import ldc_pkg::*;
#(
  parameter int PULSES = LDC_FAULT_PULSES
)(
  input wire logic i_clk,
  input wire logic i_nrst,
  ldc_dbc_if.cnt dbc
);
  localparam int CW = $clog2(PULSES + 1);
  localparam logic [CW-1:0] LAST = CW'(PULSES - 1);
  if (PULSES < 2)
  begin : g_bad_pulses
    $error("PULSES must be at least 2");
  end
  logic seen_q;
  logic [CW-1:0] cnt_q;
  logic hit_q;
  wire seen_now = seen_q | (dbc.dim_high & dbc.cond);
  wire at_last = (cnt_q == LAST);
  assign dbc.hit = hit_q;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      seen_q <= 1'b0;
      cnt_q <= '0;
      hit_q <= 1'b0;
    end
    else if (dbc.clr)
    begin
      seen_q <= 1'b0;
      cnt_q <= '0;
      hit_q <= 1'b0;
    end
    else
    begin
      seen_q <= dbc.dim_fall ? 1'b0 : seen_now;
      // any pulse without the condition restarts the run
      if (dbc.dim_fall)
        cnt_q <= !seen_now ? '0 : (at_last ? '0 : cnt_q + 1'b1);
      hit_q <= dbc.dim_fall & seen_now & at_last;
    end
  end
  AST_HIT_AFTER_RUN: assert property (@(posedge i_clk) disable iff (!i_nrst)
    hit_q |-> $past(at_last) && $past(dbc.dim_fall))
    else $error("fault hit without a full pulse run");
endmodule // ldc_fault_cnt

// *** core/ldc_pkg.sv ***
// constants and types shared by the diagnostic port core and its fault counters
// assumes a single 200 MHz clock domain and an APB register bus
package ldc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] LDC_OFS_CTRL = 8'h00;
  localparam logic [7:0] LDC_OFS_STAT = 8'h04;
  localparam logic [7:0] LDC_OFS_CMD = 8'h08;
  localparam int LDC_CTRL_CMD_EN_BIT = 0;
  localparam int LDC_CTRL_SOFT_CLR_BIT = 1;
  localparam logic [1:0] LDC_CTRL_RST = 2'h1;
  localparam int LDC_STAT_PAT_LSB = 0;
  localparam int LDC_STAT_VALID_BIT = 4;
  localparam int LDC_STAT_PGOOD_BIT = 5;
  localparam int LDC_STAT_HOT_BIT = 6;
  localparam int LDC_STAT_CH1_BIT = 7;
  localparam int LDC_STAT_FREQ_LSB = 8;
  // ****************************************
  // fault patterns and commands
  // ****************************************
  localparam logic [3:0] LDC_PAT_OV1 = 4'h1;
  localparam logic [3:0] LDC_PAT_OV2 = 4'h3;
  localparam logic [3:0] LDC_PAT_UV1 = 4'h5;
  localparam logic [3:0] LDC_PAT_UV2 = 4'h7;
  localparam logic [15:0] LDC_CMD_NORM = 16'hF777;
  localparam logic [15:0] LDC_CMD_DN20 = 16'hF111;
  localparam logic [15:0] LDC_CMD_DN40 = 16'hF333;
  localparam logic [15:0] LDC_CMD_CH1_OFF = 16'hF555;
  localparam int LDC_FAULT_PULSES = 508;
  localparam int LDC_SYNC_W = 12;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    LDC_FREQ_NORM = 2'b00,
    LDC_FREQ_DN20 = 2'b01,
    LDC_FREQ_DN40 = 2'b10
  } ldc_freq_t;
  typedef enum logic [1:0] {
    LDC_ST_START = 2'b00,
    LDC_ST_IDLE = 2'b01,
    LDC_ST_HOT = 2'b10,
    LDC_ST_REPORT = 2'b11
  } ldc_state_t;
endpackage

// *** tb/ldc_diag_port_tb.sv ***
// self-checking bench for the diagnostic port: apb reads plus a pwm/line controller model
// assumes the fault count parameter is shortened to 4 pulses
`timescale 1ns/10ps
module ldc_diag_port_tb;
  import ldc_pkg::*;
  // ****************************************
  // signals and helpers
  // ****************************************
  localparam int NP = 4;
  localparam logic [1:0] M [4] = '{2'b01, 2'b10, 2'b01, 2'b10};
  localparam logic [3:0] PAT [4] = '{LDC_PAT_OV1, LDC_PAT_OV2, LDC_PAT_UV1, LDC_PAT_UV2};
  localparam logic [15:0] CMDS [3] = '{LDC_CMD_DN20, LDC_CMD_DN40, LDC_CMD_NORM};
  localparam logic [1:0] FS [3] = '{2'h1, 2'h2, 2'h0};
  logic clk, nrst, psel, penable, pwrite, en, sd, hot, pg, hdr, mcu_low, pwm1, pwm2;
  logic pready, pslverr, oe, line_o, ch1, err, b;
  logic [7:0] paddr, got;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] snk_lo, snk_hi, sink_en, freq;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  wire line = !(oe | mcu_low);

  ldc_diag_port #(.PULSES(NP)) ldc_diag_port_i (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CHANNEL_ONE_PWM(pwm1),
    .I_CHANNEL_TWO_PWM(pwm2), .I_ENABLE(en), .I_SHUTDOWN(sd), .I_OVER_TEMP(hot),
    .I_POWER_GOOD(pg), .I_SINK_LOW(snk_lo), .I_SINK_HIGH(snk_hi), .I_HEADROOM_MAX(hdr),
    .I_DIAG_IO_LINE_I(line), .O_DIAG_IO_LINE_O(line_o), .O_DIAG_IO_LINE_OE(oe),
    .O_SINK_EN(sink_en), .O_FREQ_SEL(freq), .O_CH1_EN(ch1));
  ldc_mcu_model ldc_mcu_model_i (.i_clk(clk), .i_line(line), .o_pwm1(pwm1), .o_pwm2(pwm2),
    .o_drive_low(mcu_low));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = !clk;
  end

  // the tests need about 20000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int w;
    w = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // only the bench timeout bounds this wait; the latency is then checked to be 2 edges
    do
    begin
      @(posedge clk);
      w++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready wait", w, 32'h2);
  endtask

  task automatic stat(input string w, input logic [31:0] e);
    apb(1'b0, LDC_OFS_STAT, 32'h0);
    chk(w, rd, e);
  endtask

  task automatic pls(input logic [1:0] m, input int n);
    repeat (n) ldc_mcu_model_i.pulse(m, 1'b0, 1'b0, b);
  endtask

  task automatic sinks(input logic [1:0] m, input logic [1:0] e);
    fork
      pls(m, 1);
      begin
        repeat (30) @(posedge clk);
        chk("sink enables", {30'h0, sink_en}, {30'h0, e});
      end
    join
  endtask

  task automatic cond(input int i, input logic v);
    @(posedge clk);
    if (i < 2)
      snk_hi[i % 2] <= v;
    else
      snk_lo[i % 2] <= v;
    hdr <= v;
  endtask

  task automatic en_pulse();
    en <= 1'b0;
    repeat (40) @(posedge clk);
    en <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    en = 1'b1;
    sd = 1'b0;
    hot = 1'b0;
    pg = 1'b0;
    hdr = 1'b0;
    snk_lo = 2'h0;
    snk_hi = 2'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    chk("line at start", {31'h0, oe}, 32'h1);
    chk("line drive level", {31'h0, line_o}, 32'h0);
    apb(1'b0, LDC_OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    stat("stat reset", 32'h80);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    ldc_mcu_model_i.send_cmd(LDC_CMD_DN20);
    chk("freq before pgood", {30'h0, freq}, 32'h0);
    pg <= 1'b1;
    repeat (8) @(posedge clk);
    chk("line at pgood", {31'h0, oe}, 32'h0);
    sinks(2'b01, 2'b01);
    chk("line static", {31'h0, oe}, 32'h0);
    foreach (CMDS[i])
    begin
      ldc_mcu_model_i.send_cmd(CMDS[i]);
      chk("freq", {30'h0, freq}, {30'h0, FS[i]});
    end
    ldc_mcu_model_i.send_cmd(LDC_CMD_CH1_OFF);
    chk("ch1 enable", {31'h0, ch1}, 32'h0);
    apb(1'b0, LDC_OFS_CMD, 32'h0);
    chk("last command", rd, 32'h0000F555);
    sinks(2'b11, 2'b10);
    ldc_mcu_model_i.send_cmd(LDC_CMD_DN40);
    chk("freq with ch1 off", {30'h0, freq}, 32'h2);
    en_pulse();
    chk("freq after enable", {30'h0, freq}, 32'h0);
    chk("ch1 after enable", {31'h0, ch1}, 32'h1);
    apb(1'b1, LDC_OFS_CTRL, 32'h0);
    chk("write error", {31'h0, err}, 32'h0);
    ldc_mcu_model_i.send_cmd(LDC_CMD_DN20);
    chk("freq with commands off", {30'h0, freq}, 32'h0);
    apb(1'b1, LDC_OFS_CTRL, 32'h1);
    apb(1'b0, LDC_OFS_CTRL, 32'h0);
    chk("ctrl written", rd, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      cond(i, 1'b1);
      pls(M[i], NP - 1);
      stat("below count", 32'hA0);
      pls(M[i], 1);
      cond(i, 1'b0);
      pls(M[i], 1);
      stat("latched", 32'hB0 | PAT[i]);
      if (i == 0)
      begin
        for (int k = 7; k >= 0; k--)
        begin
          ldc_mcu_model_i.pulse(2'b01, 1'b0, 1'b0, b);
          got[k] = b;
        end
        chk("serial", {24'h0, got}, {24'h0, {2{PAT[0][1:0], PAT[0][3:2]}}});
        ldc_mcu_model_i.send_cmd(LDC_CMD_DN20);
        chk("freq with pattern", {30'h0, freq}, 32'h0);
      end
      if (i == 1)
      begin
        sd <= 1'b1;
        repeat (8) @(posedge clk);
        sd <= 1'b0;
        repeat (8) @(posedge clk);
      end
      else
      begin
        if (i == 2)
        begin
          hot <= 1'b1;
          repeat (8) @(posedge clk);
          chk("line hot", {31'h0, oe}, 32'h1);
          hot <= 1'b0;
          repeat (8) @(posedge clk);
          stat("resumed", 32'hB0 | PAT[i]);
        end
        if (i == 3)
        begin
          apb(1'b1, LDC_OFS_CTRL, 32'h3);
          stat("soft cleared", 32'hA0);
          apb(1'b0, LDC_OFS_CTRL, 32'h0);
          chk("ctrl after soft clear", rd, 32'h1);
        end
        en_pulse();
      end
      stat("cleared", 32'hA0);
    end
    cond(3, 1'b1);
    pls(M[3], NP - 1);
    stat("after clear", 32'hA0);
    report_and_stop();
  end
endmodule // ldc_diag_port_tb

// *** tb/ldc_mcu_model.sv ***
// microcontroller model: drives both pwm inputs and the open-drain diagnostic line
// assumes the bench resolves the line with a pull-up and feeds it back on i_line
`timescale 1ns/10ps
module ldc_mcu_model #(
  parameter int HALF = 60
)(
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_pwm1,
  output logic o_pwm2,
  output logic o_drive_low
);
  // ****************************************
  // pulse and command tasks
  // ****************************************
  initial
  begin
    o_pwm1 = 1'b0;
    o_pwm2 = 1'b0;
    o_drive_low = 1'b0;
  end

  // one pulse per call; the bit is held across the fall, the line is sampled after it
  task automatic pulse(input logic [1:0] m, input logic drv, input logic bt, output logic s);
    @(posedge i_clk);
    o_pwm1 <= m[0];
    o_pwm2 <= m[1];
    o_drive_low <= drv & !bt;
    repeat (HALF) @(posedge i_clk);
    o_pwm1 <= 1'b0;
    o_pwm2 <= 1'b0;
    // late sampling leaves room for a slow rising edge
    repeat (HALF / 2) @(posedge i_clk);
    s = i_line;
    o_drive_low <= 1'b0;
    repeat (HALF / 2 - 1) @(posedge i_clk);
  endtask

  task automatic send_cmd(input logic [15:0] c);
    logic s;
    for (int i = 15; i >= 0; i--)
      pulse(2'b01, 1'b1, c[i], s);
  endtask
endmodule // ldc_mcu_model
